// >>> rtl/eiw_defs.svh
// constants for the external interrupt edge and wake block
`ifndef EIW_DEFS_SVH
`define EIW_DEFS_SVH
`define EIW_NUM_LINES     5
`define EIW_LINE_ZERO     0
`define EIW_LINE_ONE      1
`define EIW_LINE_TWO      2
`define EIW_LINE_THREE    3
`define EIW_LINE_FOUR     4
`define EIW_TIMER_CONTROL_REG_IT0_BIT  0
`define EIW_TIMER_CONTROL_REG_IT1_BIT  2
`define EIW_CLKO_T2_BIT   2
`define EIW_SYNC_RESET    1'b1
`endif

// >>> rtl/eiw_edge_line.sv
// one interrupt line: synchroniser, edge detect and pending flag
`timescale 1ns/1ns
`include "eiw_defs.svh"
module eiw_edge_line
    import eiw_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      resetn,
    input  wire logic      pin_in,
    input  wire eiw_edge_t edge_mode,
    input  wire logic      clear,
    output logic           pending,
    output logic           edge_seen
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic pend_reg;
    logic seen_reg;
    logic fall_w;
    logic rise_w;
    logic hit_w;

    // two flops before any logic looks at the pad  [R9]
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= `EIW_SYNC_RESET;
            sync_reg <= `EIW_SYNC_RESET;
            last_reg <= `EIW_SYNC_RESET;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // qualify the edge by mode
    assign fall_w = last_reg & ~sync_reg;
    assign rise_w = ~last_reg & sync_reg;
    assign hit_w  = fall_w | (rise_w & (edge_mode == EIW_EDGE_BOTH));

    // set beats clear so an edge in the clearing cycle is kept  [R9]
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            pend_reg <= 1'b0;
            seen_reg <= 1'b0;
        end
        else
        begin
            pend_reg <= hit_w | (pend_reg & ~clear);
            seen_reg <= hit_w;
        end
    end

    assign pending   = pend_reg;
    assign edge_seen = seen_reg;
endmodule // eiw_edge_line

// >>> rtl/eiw_pkg.sv
// types for the external interrupt edge and wake block
package eiw_pkg;
    typedef enum logic [1:0] {
        EIW_EDGE_FALL = 2'b00,
        EIW_EDGE_BOTH = 2'b01
    } eiw_edge_t;
endpackage

// >>> rtl/eiw_top.sv
// external interrupt edge detection, power-down wake and t2 clock pin mux
// Summary of operation
// R1 - line zero, select bit 0: request on both rising and falling edges.
// R2 - line one, select bit 1: request on falling edges only.
// R3 - line one, select bit 0: request on both edges.
// R4 - valid edge on line one wakes the device from power-down.
// R5 - line two requests on falling edges only and wakes from power-down.
// R6 - line three requests on falling edges only and wakes from power-down.
// R7 - valid edge on line four wakes the device from power-down.
// R8 - clock-output bit 2 set: shared pin drives timer 2 clock output.
// R9 - edges set sticky pending; cleared by ack or software; inputs synchronised.
// R10 - line zero, select bit 1: request on falling edges only.
`timescale 1ns/1ns
`include "eiw_defs.svh"
module eiw_top
    import eiw_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [4:0] ext_irq_pins,
    input  wire logic [7:0] timer_control_reg,
    input  wire logic [7:0] clock_output_control,
    input  wire logic [4:0] irq_ack,
    input  wire logic [4:0] irq_sw_clear,
    input  wire logic       power_down,
    input  wire logic       timer2_clock_out,
    input  wire logic       shared_pin_alt_out,
    input  wire logic       shared_pin_alt_oe,
    output logic [4:0]      irq_pending,
    output logic            wake_up,
    output logic            shared_pin_out,
    output logic            shared_pin_oe
);
    logic [4:0] pend_w;
    logic [4:0] seen_w;
    logic [4:0] clr_w;
    eiw_edge_t  mode_w [0:4];
    logic       wake_reg;
    logic       pout_reg;
    logic       poe_reg;
    logic       t2_sel_w;
    logic       wake_src_w;

    // edge mode per line; lines two and three are fixed to falling
    assign mode_w[`EIW_LINE_ZERO] =
        timer_control_reg[`EIW_TIMER_CONTROL_REG_IT0_BIT] ? EIW_EDGE_FALL
                                              : EIW_EDGE_BOTH; // [R1] [R10]
    assign mode_w[`EIW_LINE_ONE] =
        timer_control_reg[`EIW_TIMER_CONTROL_REG_IT1_BIT] ? EIW_EDGE_FALL
                                              : EIW_EDGE_BOTH; // [R2] [R3]
    assign mode_w[`EIW_LINE_TWO]   = EIW_EDGE_FALL; // [R5]
    assign mode_w[`EIW_LINE_THREE] = EIW_EDGE_FALL; // [R6]
    // line four has no select bit; falling only like the other fixed lines
    assign mode_w[`EIW_LINE_FOUR]  = EIW_EDGE_FALL;

    assign clr_w = irq_ack | irq_sw_clear; // [R9]

    genvar gi;
    generate
        for (gi = 0; gi < `EIW_NUM_LINES; gi = gi + 1)
        begin : g_line
            eiw_edge_line u_line (
                .mclk      (mclk),
                .resetn    (resetn),
                .pin_in    (ext_irq_pins[gi]),
                .edge_mode (mode_w[gi]),
                .clear     (clr_w[gi]),
                .pending   (pend_w[gi]),
                .edge_seen (seen_w[gi])
            );
        end
    endgenerate

    // line zero cannot wake; the others can while powered down
    assign wake_src_w = seen_w[`EIW_LINE_ONE]              // [R4]
                      | seen_w[`EIW_LINE_TWO]              // [R5]
                      | seen_w[`EIW_LINE_THREE]            // [R6]
                      | seen_w[`EIW_LINE_FOUR];            // [R7]
    assign t2_sel_w = clock_output_control[`EIW_CLKO_T2_BIT];

    // registered outputs; wake is a one-cycle pulse
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wake_reg <= 1'b0;
            pout_reg <= 1'b0;
            poe_reg  <= 1'b0;
        end
        else
        begin
            wake_reg <= power_down & wake_src_w; // [R4] [R7]
            pout_reg <= t2_sel_w ? timer2_clock_out : shared_pin_alt_out; // [R8]
            poe_reg  <= t2_sel_w | shared_pin_alt_oe; // [R8]
        end
    end

    assign irq_pending    = pend_w;
    assign wake_up        = wake_reg;
    assign shared_pin_out = pout_reg;
    assign shared_pin_oe  = poe_reg;
endmodule // eiw_top

// >>> sim/eiw_pin_drv.sv
// pad model driving the external interrupt pins
`timescale 1ns/1ns
module eiw_pin_drv(
    input  wire logic       mclk,
    input  wire logic [4:0] want,
    output logic      [4:0] pins
);
    // levels change only on an edge, so each one lasts a whole cycle
    always @(posedge mclk)
        pins <= want;
endmodule // eiw_pin_drv

// >>> sim/eiw_top_props.sv
// checker for edge detect, wake and pin mux
`timescale 1ns/1ns
module eiw_props(input wire logic mclk, resetn, power_down, timer2_clock_out,
    wake_up, shared_pin_out, shared_pin_oe,
    input wire logic [4:0] ext_irq_pins, irq_ack, irq_sw_clear, irq_pending,
    input wire logic [7:0] timer_control_reg, clock_output_control);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // a new request needs a qualifying pin edge three samples back
    AST_L0_EDGE: assert property ($rose(irq_pending[0]) |->
        $past(ext_irq_pins[0],4) != $past(ext_irq_pins[0],3) &&
        ($past(ext_irq_pins[0],4) || !$past(timer_control_reg[0],3)))
        else $error("line zero request without valid edge");
    AST_L1_EDGE: assert property ($rose(irq_pending[1]) |->
        $past(ext_irq_pins[1],4) != $past(ext_irq_pins[1],3) &&
        ($past(ext_irq_pins[1],4) || !$past(timer_control_reg[2],3)))
        else $error("line one request without valid edge");
    AST_L2_FALL: assert property ($rose(irq_pending[2]) |->
        $past(ext_irq_pins[2],4) && !$past(ext_irq_pins[2],3))
        else $error("line two request without falling edge");
    AST_L3_SET: assert property ($fell(ext_irq_pins[3]) |->
        ##3 irq_pending[3]) else $error("line three edge not latched");
    AST_STICKY: assert property (irq_pending[2] && !irq_ack[2] &&
        !irq_sw_clear[2] |=> irq_pending[2]) else $error("request lost");
    AST_WAKE: assert property ((irq_pending[4:1] &
        ~$past(irq_pending[4:1])) != 0 && power_down |=> wake_up)
        else $error("no wake on edge in power-down");
    AST_WAKE_SRC: assert property (wake_up |->
        $past(power_down) ##1 !wake_up) else $error("stray wake pulse");
    AST_MUX: assert property (clock_output_control[2] |=>
        shared_pin_oe && shared_pin_out == $past(timer2_clock_out))
        else $error("shared pin not on timer 2 clock");
endmodule // eiw_props
bind eiw_top eiw_props u_props(.*);

// >>> sim/ext_irq_edge_detect_wake_tb.sv
// testbench: pin edges, pending, wake and pin mux checks
`timescale 1ns/1ns
module ext_irq_edge_detect_wake_tb;
    logic mclk = 0, resetn = 0, pd = 0, t2 = 0, woke = 0, wake, spo, spoe;
    logic [4:0] want = 5'h1f, ack = 0, clr = 0, pins, pend;
    logic [7:0] tcr = 0, coc = 0;
    int n_errors = 0, num_checks = 0, cyc = 0;
    always #5 mclk = ~mclk;
    eiw_pin_drv PIN (.mclk(mclk), .want(want), .pins(pins));
    eiw_top DUT (.mclk(mclk), .resetn(resetn), .ext_irq_pins(pins),
        .timer_control_reg(tcr), .clock_output_control(coc), .irq_ack(ack),
        .irq_sw_clear(clr), .power_down(pd), .timer2_clock_out(t2),
        .shared_pin_alt_out(1'b1), .shared_pin_alt_oe(1'b0),
        .irq_pending(pend), .wake_up(wake), .shared_pin_out(spo),
        .shared_pin_oe(spoe));
    task close_out;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(string nm, logic [4:0] e, logic [4:0] s);
        num_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one pin move, then long enough for the request to land
    task step(int n, logic v);
        @(posedge mclk) want[n] <= v;
        repeat (6) @(posedge mclk);
        // look off the edge so the latched wake flag has settled
        @(negedge mclk);
    endtask
    // low lines cleared by ack, line four by software clear
    task wipe;
        @(posedge mclk) {ack, clr, woke} <= {5'h0f, 5'h10, 1'b0};
        @(posedge mclk) {ack, clr} <= 0;
    endtask
    task t_sel;
        for (int s = 0; s < 2; s++)
            for (int n = 0; n < 2; n++)
            begin
                tcr <= {5'h0, s[0], 1'b0, s[0]};
                step(n, 0);
                chk("fall", 5'h1 << n, pend);
                chk("wake", 5'(n), {4'h0, woke});
                wipe;
                step(n, 1);
                chk("rise", s ? 5'h0 : 5'h1 << n, pend);
                wipe;
            end
    endtask
    task t_fall;
        for (int i = 2; i < 5; i++)
        begin
            step(i, 0);
            chk("fall", 5'h1 << i, pend);
            chk("wake", 5'h1, {4'h0, woke});
            wipe;
            step(i, 1);
            chk("rise", 5'h0, pend);
        end
    endtask
    task t_mux;
        @(posedge mclk) coc <= 8'h04;
        repeat (2) @(posedge mclk);
        @(negedge mclk) chk("t2", {1'b1, 3'h0, ~t2}, {spoe, 3'h0, spo});
        @(posedge mclk) coc <= 8'h00;
        repeat (2) @(negedge mclk);
        chk("oe", 5'h1, {3'h0, spoe, spo});
    endtask
    // an edge while awake must not pulse wake
    task t_nopd;
        @(posedge mclk) pd <= 1'b0;
        step(2, 0);
        chk("nowake", 5'h0, {4'h0, woke});
        wipe;
        step(2, 1);
        @(posedge mclk) pd <= 1'b1;
    endtask
    // timer 2 clock toggles every cycle; wake pulses are latched
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        t2 <= ~t2;
        if (wake === 1'b1)
            woke <= 1'b1;
        if (cyc == 1000)
        begin
            n_errors++;
            close_out;
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        {resetn, pd} <= 2'b11;
        t_sel;
        t_fall;
        t_nopd;
        t_mux;
        close_out;
    end
endmodule // ext_irq_edge_detect_wake_tb
